// ===== design/timer_event_capture_defines.vh
/*
 * register offsets, field positions, reset values and encodings of the
 * timer event capture block.
 * assumes: included by bare name from the design files.
 */
`ifndef TIMER_EVENT_CAPTURE_DEFINES_VH
`define TIMER_EVENT_CAPTURE_DEFINES_VH

// ==========================================================================
// register offsets (byte addresses)
`define OFS_CONTROL          8'h00
`define OFS_EVENT_CONTROL    8'h04
`define OFS_INT_ENABLE_CLEAR 8'h08
`define OFS_INT_ENABLE_SET   8'h0C
`define OFS_FLAGS            8'h10
`define OFS_COUNT            8'h14
`define OFS_CAPTURE_ZERO     8'h18
`define OFS_CAPTURE_ONE      8'h1C

// ==========================================================================
// control fields
`define CTL_RUN              0
`define CTL_DOWN             1
`define CTL_CAPEN0           2
`define CTL_CAPEN1           3

// ==========================================================================
// event control fields
`define EVC_ACT_LSB          0
`define EVC_ACT_MSB          2
`define EVC_INVERT           4
`define EVC_INPUT_EN         5
`define EVC_OVF_OUT_EN       8

// ==========================================================================
// flag and interrupt enable fields
`define FLG_OVF              0
`define FLG_ERR              1
`define FLG_MC0              4
`define FLG_MC1              5
`define FLG_WIDTH            8

// ==========================================================================
// event actions
`define ACT_OFF              3'h0
`define ACT_RETRIGGER        3'h1
`define ACT_COUNT            3'h2
`define ACT_START            3'h3
`define ACT_STAMP            3'h4
`define ACT_PPW              3'h5
`define ACT_PWP              3'h6
`define ACT_PW               3'h7

// ==========================================================================
// reset values and limits
`define RST_CONTROL          4'h0
`define RST_EVENT_CONTROL    9'h000
`define RST_INT_ENABLE       8'h00
`define RST_FLAGS            8'h00
`define COUNT_ZERO           16'h0000
`define COUNT_MAX            16'hFFFF

`endif

// ===== design/event_edge_detect.v
/*
 * conditions the event input: invert, enable, edge detect.
 * assumes: event level synchronous to clk_sys.
 */
`include "timer_event_capture_defines.vh"

module event_edge_detect
(
    // clock and reset
    input  wire clk_sys,
    input  wire sys_rst,
    // event source and settings
    input  wire event_level,
    input  wire event_input_invert,
    input  wire event_input_enable,
    // detected edges
    output reg  event_rise,
    output reg  event_fall
);

    // ======================================================================
    // polarity and edges
    wire cond_level;
    reg  prev_level;

    assign cond_level = event_level ^ event_input_invert;

    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            prev_level <= 1'b0;
            event_rise <= 1'b0;
            event_fall <= 1'b0;
        end
        else
        begin
            prev_level <= cond_level;
            event_rise <= event_input_enable & cond_level & ~prev_level;
            event_fall <= event_input_enable & ~cond_level & prev_level;
        end
    end

endmodule

// ===== design/timer_event_capture.v
/*
 * event input, counter and two capture channels of a basic timer unit.
 * assumes: event channel level synchronous to clk_sys; register port
 * with one-cycle strobes, read data valid in the following cycle.
 */
// Strobed register access was decided locally.
// Overview of operation
// - combined captures use rising and falling edges
// - action 0x6: period in one, width zero
// - action 0x5: period in zero, width one
// - inverted input moves wraparound to falling edge
// - capture on set flag: drop, set error
// - capture only when enabled, else compare mode
// - action 0x7: fall clears, halts; rise restarts
// - overflow event output only when bit 8 set
// - bit 5 gates incoming events
// - bit 4 inverts event source polarity
// - action field selects none/retrigger/count/start/stamp
// - enable clear write disables, visible in set
`include "timer_event_capture_defines.vh"

module timer_event_capture
(
    // clock and reset
    input  wire        clk_sys,
    input  wire        sys_rst,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [31:0] reg_rdata,
    // event channel
    input  wire        event_in,
    output reg         overflow_event_out
);

    // ======================================================================
    // registers
    reg  [3:0]  control;
    reg  [8:0]  event_control;
    reg  [7:0]  interrupt_enable_set;
    reg  [7:0]  flags;
    reg  [15:0] count;
    reg  [15:0] capture_reg_zero;
    reg  [15:0] capture_reg_one;
    reg         start_seen;
    reg         width_halt;

    wire [2:0]  event_action_select;
    wire        event_input_invert;
    wire        event_input_enable;
    wire        overflow_event_out_enable;
    wire [1:0]  capture_mode_enable;
    wire        event_rise;
    wire        event_fall;

    assign event_action_select       = event_control[`EVC_ACT_MSB:`EVC_ACT_LSB];
    assign event_input_invert        = event_control[`EVC_INVERT];
    assign event_input_enable        = event_control[`EVC_INPUT_EN];
    assign overflow_event_out_enable = event_control[`EVC_OVF_OUT_EN];
    assign capture_mode_enable       = {control[`CTL_CAPEN1], control[`CTL_CAPEN0]};

    // ======================================================================
    // event conditioning
    event_edge_detect edge_unit
    (
        .clk_sys            (clk_sys),
        .sys_rst            (sys_rst),
        .event_level        (event_in),
        .event_input_invert (event_input_invert),
        .event_input_enable (event_input_enable),
        .event_rise         (event_rise),
        .event_fall         (event_fall)
    );

    // ======================================================================
    // counting decision
    reg         counting;
    reg         count_tick;
    reg         wrap_clear;
    reg         at_limit;
    reg  [15:0] next_count;

    always @*
    begin
        counting   = control[`CTL_RUN];
        count_tick = 1'b0;
        wrap_clear = 1'b0;
        case (event_action_select)
            `ACT_OFF:       count_tick = counting;
            `ACT_RETRIGGER: begin
                                count_tick = counting;
                                wrap_clear = event_rise;
                            end
            `ACT_COUNT:     count_tick = counting & event_rise;
            `ACT_START:     count_tick = counting & start_seen;
            `ACT_STAMP:     count_tick = counting;
            `ACT_PPW,
            `ACT_PWP:       begin
                                count_tick = counting;
                                wrap_clear = event_rise;
                            end
            `ACT_PW:        begin
                                count_tick = counting & ~width_halt & ~event_fall;
                                wrap_clear = event_fall;
                            end
            default:        count_tick = 1'b0;
        endcase
        at_limit = control[`CTL_DOWN] ? (count == `COUNT_ZERO) : (count == `COUNT_MAX);
        if (wrap_clear & counting)
            next_count = `COUNT_ZERO;
        else if (count_tick)
            next_count = control[`CTL_DOWN] ? count - 16'h0001 : count + 16'h0001;
        else
            next_count = count;
    end

    wire wrap_event;
    assign wrap_event = count_tick & at_limit & ~(wrap_clear & counting);

    // ======================================================================
    // capture requests per channel
    reg        cap_req0;
    reg        cap_req1;
    reg [15:0] cap_val0;
    reg [15:0] cap_val1;

    always @*
    begin
        cap_req0 = 1'b0;
        cap_req1 = 1'b0;
        cap_val0 = count;
        cap_val1 = count;
        case (event_action_select)
            `ACT_STAMP: cap_req0 = event_rise;
            `ACT_PPW:   begin
                            cap_req0 = event_rise;
                            cap_req1 = event_fall;
                        end
            `ACT_PWP:   begin
                            cap_req1 = event_rise;
                            cap_req0 = event_fall;
                        end
            `ACT_PW:    cap_req0 = event_fall;
            default:    begin
                            cap_req0 = 1'b0;
                            cap_req1 = 1'b0;
                        end
        endcase
        if (~counting)
        begin
            cap_req0 = 1'b0;
            cap_req1 = 1'b0;
        end
    end

    // ======================================================================
    // per-channel capture and compare
    wire [1:0]  cap_req;
    wire [1:0]  store;
    wire [1:0]  cap_error;
    wire [1:0]  match;
    wire [1:0]  channel_capture_flag;
    wire [31:0] cap_val;
    wire [31:0] cc_now;

    assign cap_req              = {cap_req1, cap_req0};
    assign cap_val              = {cap_val1, cap_val0};
    assign cc_now               = {capture_reg_one, capture_reg_zero};
    assign channel_capture_flag = {flags[`FLG_MC1], flags[`FLG_MC0]};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : chan
            assign store[ch]     = cap_req[ch] & capture_mode_enable[ch]
                                   & ~channel_capture_flag[ch];
            assign cap_error[ch] = cap_req[ch] & capture_mode_enable[ch]
                                   & channel_capture_flag[ch];
            assign match[ch]     = ~capture_mode_enable[ch] & count_tick
                                   & (count == cc_now[16*ch+15:16*ch]);
        end
    endgenerate

    // ======================================================================
    // register writes
    wire wr_control;
    wire wr_event;
    wire wr_ien_clr;
    wire wr_ien_set;
    wire wr_flags;
    wire wr_count;
    wire wr_cc0;
    wire wr_cc1;

    assign wr_control = reg_write & (reg_addr == `OFS_CONTROL);
    assign wr_event   = reg_write & (reg_addr == `OFS_EVENT_CONTROL);
    assign wr_ien_clr = reg_write & (reg_addr == `OFS_INT_ENABLE_CLEAR);
    assign wr_ien_set = reg_write & (reg_addr == `OFS_INT_ENABLE_SET);
    assign wr_flags   = reg_write & (reg_addr == `OFS_FLAGS);
    assign wr_count   = reg_write & (reg_addr == `OFS_COUNT);
    assign wr_cc0     = reg_write & (reg_addr == `OFS_CAPTURE_ZERO);
    assign wr_cc1     = reg_write & (reg_addr == `OFS_CAPTURE_ONE);

    reg [7:0] flag_set;

    always @*
    begin
        flag_set            = 8'h00;
        flag_set[`FLG_OVF]  = wrap_event;
        flag_set[`FLG_ERR]  = |cap_error;
        flag_set[`FLG_MC0]  = store[0] | match[0];
        flag_set[`FLG_MC1]  = store[1] | match[1];
    end

    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            control              <= `RST_CONTROL;
            event_control        <= `RST_EVENT_CONTROL;
            interrupt_enable_set <= `RST_INT_ENABLE;
            flags                <= `RST_FLAGS;
        end
        else
        begin
            if (wr_control)
                control <= reg_wdata[3:0];
            if (wr_event)
                event_control <= reg_wdata[8:0];
            if (wr_ien_clr)
                interrupt_enable_set <= interrupt_enable_set & ~reg_wdata[7:0];
            else if (wr_ien_set)
                interrupt_enable_set <= interrupt_enable_set | reg_wdata[7:0];
            // set wins over a simultaneous write-one clear
            flags <= (flags & ~(wr_flags ? reg_wdata[7:0] : 8'h00)) | flag_set;
        end
    end

    // ======================================================================
    // counter, start and halt state, capture registers
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            count            <= `COUNT_ZERO;
            capture_reg_zero <= `COUNT_ZERO;
            capture_reg_one  <= `COUNT_ZERO;
            start_seen       <= 1'b0;
            width_halt       <= 1'b0;
        end
        else
        begin
            count <= wr_count ? reg_wdata[15:0] : next_count;
            if (~control[`CTL_RUN] | (event_action_select != `ACT_START))
                start_seen <= 1'b0;
            else if (event_rise)
                start_seen <= 1'b1;
            if (event_action_select != `ACT_PW)
                width_halt <= 1'b0;
            else if (event_fall)
                width_halt <= 1'b1;
            else if (event_rise)
                width_halt <= 1'b0;
            if (store[0])
                capture_reg_zero <= cap_val[15:0];
            else if (wr_cc0)
                capture_reg_zero <= reg_wdata[15:0];
            if (store[1])
                capture_reg_one <= cap_val[31:16];
            else if (wr_cc1)
                capture_reg_one <= reg_wdata[15:0];
        end
    end

    // ======================================================================
    // overflow output event and read port
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            overflow_event_out <= 1'b0;
            reg_rdata          <= 32'h00000000;
        end
        else
        begin
            overflow_event_out <= wrap_event & overflow_event_out_enable;
            reg_rdata          <= 32'h00000000;
            if (reg_read)
            begin
                case (reg_addr)
                    `OFS_CONTROL:          reg_rdata <= {28'h0000000, control};
                    `OFS_EVENT_CONTROL:    reg_rdata <= {23'h000000, event_control};
                    `OFS_INT_ENABLE_CLEAR,
                    `OFS_INT_ENABLE_SET:   reg_rdata <= {24'h000000, interrupt_enable_set};
                    `OFS_FLAGS:            reg_rdata <= {24'h000000, flags};
                    `OFS_COUNT:            reg_rdata <= {16'h0000, count};
                    `OFS_CAPTURE_ZERO:     reg_rdata <= {16'h0000, capture_reg_zero};
                    `OFS_CAPTURE_ONE:      reg_rdata <= {16'h0000, capture_reg_one};
                    default:               reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// ===== test/timer_event_capture_monitor.sv
/* port checker for timer_event_capture.
   assumes: bound to the top module; one clock, sync reset. */
module timer_event_capture_monitor
(
    // clock and reset
    input wire        clk_sys,
    input wire        sys_rst,
    // register port
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_write,
    input wire        reg_read,
    input wire [31:0] reg_rdata,
    // event channel
    input wire        event_in,
    input wire        overflow_event_out
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [3:0] ctl;
    reg [8:0] evc;
    reg [7:0] ien;
    reg [7:0] seen;
    reg [7:0] ra;
    reg       rd_d;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ========
    // shadow copies of written settings
    always @(posedge clk_sys)
    begin
        rd_d <= reg_read && !sys_rst;
        ra   <= reg_addr;
        if (sys_rst)
        begin
            ctl  <= 4'h0;
            evc  <= 9'h000;
            ien  <= 8'h00;
            seen <= 8'h00;
        end
        else
        begin
            if (reg_write && reg_addr == 8'h00)
                ctl <= reg_wdata[3:0];
            if (reg_write && reg_addr == 8'h04)
                evc <= reg_wdata[8:0] & 9'h137;
            if (reg_write && reg_addr == 8'h0C)
                ien <= ien | (reg_wdata[7:0] & 8'h33);
            if (reg_write && reg_addr == 8'h08)
                ien <= ien & ~reg_wdata[7:0];
            if (reg_write && reg_addr == 8'h10)
                seen <= seen & ~reg_wdata[7:0];
            else if (rd_d && ra == 8'h10)
                seen <= reg_rdata[7:0] & 8'h30;
        end
    end
    // ========
    // properties
    property p_rdata_idle;
        (!rd_d || ra > 8'h1C) |-> reg_rdata == 32'h0;
    endproperty
    property p_ctl_read;
        rd_d && ra == 8'h00 |-> reg_rdata == {28'h0, ctl};
    endproperty
    property p_evc_read;
        rd_d && ra == 8'h04 |-> (reg_rdata[8:0] & 9'h137) == evc;
    endproperty
    property p_ien_read;
        rd_d && (ra == 8'h08 || ra == 8'h0C) |-> (reg_rdata[7:0] & 8'h33) == ien;
    endproperty
    property p_flag_stick;
        rd_d && ra == 8'h10 |-> (reg_rdata[7:0] & seen) == seen;
    endproperty
    property p_ovf_en;
        overflow_event_out |-> evc[8] || $past(evc[8]);
    endproperty
    property p_ovf_pulse;
        overflow_event_out |=> !overflow_event_out;
    endproperty
    property p_ovf_run;
        overflow_event_out |-> $past(ctl[0]) || $past(ctl[0], 2);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read slot");
    a_ctl_read: assert property (p_ctl_read)
        else $error("control readback wrong");
    a_evc_read: assert property (p_evc_read)
        else $error("event control readback wrong");
    a_ien_read: assert property (p_ien_read)
        else $error("interrupt enable readback wrong");
    a_flag_stick: assert property (p_flag_stick)
        else $error("capture flag dropped without clear");
    a_ovf_en: assert property (p_ovf_en)
        else $error("overflow event while disabled");
    a_ovf_pulse: assert property (p_ovf_pulse)
        else $error("overflow event longer than one cycle");
    a_ovf_run: assert property (p_ovf_run)
        else $error("overflow event with counter stopped");
    c_ovf: cover property (overflow_event_out);
    c_flag: cover property (rd_d && ra == 8'h10 && reg_rdata[4]);
    c_ien: cover property (rd_d && ra == 8'h08 && reg_rdata[0]);
endmodule

// ===== test/event_source_model.sv
/* event channel model: bursts of level pulses.
   assumes: driven by the bench on clk_sys, one burst at a time. */
module event_source_model
(
    // clock and reset
    input  wire       clk_sys,
    input  wire       sys_rst,
    // burst request
    input  wire       go,
    input  wire       idle_level,
    input  wire [7:0] act_len,
    input  wire [7:0] gap_len,
    input  wire [3:0] pulses,
    // event channel
    output reg        event_in,
    output reg        busy
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [7:0] cnt;
    reg [3:0] left;
    reg       active;
    // ========
    // burst sequencer
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            event_in <= 1'b0;
            busy     <= 1'b0;
            active   <= 1'b0;
        end
        else if (!busy)
        begin
            event_in <= idle_level ^ (go && pulses != 4'h0);
            busy     <= go && pulses != 4'h0;
            left     <= pulses;
            active   <= 1'b1;
            cnt      <= act_len;
        end
        else if (cnt != 8'h01)
            cnt <= cnt - 8'h01;
        else if (active)
        begin
            event_in <= idle_level;
            active   <= 1'b0;
            left     <= left - 4'h1;
            cnt      <= gap_len;
        end
        else
        begin
            event_in <= idle_level ^ (left != 4'h0);
            busy     <= left != 4'h0;
            active   <= 1'b1;
            cnt      <= act_len;
        end
    end
endmodule

// ===== test/tb_timer_event_capture.sv
/* self-checking bench for timer_event_capture.
   assumes: design, monitor and event model compiled first. */
module tb_timer_event_capture;
    timeunit 1ns;
    timeprecision 1ns;
    reg         clk_sys = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [31:0] reg_wdata = 32'h0;
    reg         reg_write = 1'b0;
    reg         reg_read = 1'b0;
    wire [31:0] reg_rdata;
    wire        event_in;
    wire        overflow_event_out;
    reg         go = 1'b0;
    reg         idle_level = 1'b0;
    reg  [7:0]  act_len = 8'h06;
    reg  [7:0]  gap_len = 8'h28;
    reg  [3:0]  pulses = 4'h1;
    wire        busy;
    reg  [31:0] rv;
    integer     miscompares = 0;
    integer     cmp_count = 0;
    always #10 clk_sys = ~clk_sys;
    timer_event_capture uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .event_in(event_in), .overflow_event_out(overflow_event_out));
    event_source_model src (.clk_sys(clk_sys), .sys_rst(sys_rst), .go(go),
        .idle_level(idle_level), .act_len(act_len), .gap_len(gap_len), .pulses(pulses),
        .event_in(event_in), .busy(busy));
    // ========
    // bus and check helpers
    task rst;
    begin
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        idle_level <= 1'b0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
    end
    endtask
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    end
    endtask
    task chk(input [31:0] e);
    begin
        cmp_count = cmp_count + 1;
        if (rv !== e)
        begin
            miscompares = miscompares + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, rv, e);
        end
    end
    endtask
    task rd(input [7:0] a);
    begin
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
    end
    endtask
    task rc(input [7:0] a, input [31:0] e);
    begin
        rd(a);
        chk(e);
    end
    endtask
    task burst(input [7:0] a, input [7:0] g, input [3:0] n, input clr);
        integer k;
    begin
        @(posedge clk_sys);
        act_len <= a;
        gap_len <= g;
        pulses  <= n;
        go      <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (15) @(posedge clk_sys);
        if (clr)
            wr(8'h10, 32'h33);
        for (k = 0; k < 600 && busy === 1'b1; k = k + 1)
            @(posedge clk_sys) #1;
        repeat (4) @(posedge clk_sys);
    end
    endtask
    task watch;
        integer k;
    begin
        rv = 32'h0;
        for (k = 0; k < 40; k = k + 1)
        begin
            @(posedge clk_sys) #1;
            if (overflow_event_out === 1'b1)
                rv = 32'h1;
        end
    end
    endtask
    // ========
    // scenarios
    task t_regs;
        reg [7:0] a;
    begin
        rst;
        for (a = 8'h00; a < 8'h24; a = a + 8'h04)
            rc(a, 32'h0);
        wr(8'h0C, 32'h33);
        rc(8'h08, 32'h33);
        wr(8'h08, 32'h03);
        rc(8'h0C, 32'h30);
        $display("t_regs done");
    end
    endtask
    task t_capture(input [2:0] act, input inv, input [7:0] o_per, input [7:0] o_wid);
    begin
        rst;
        @(posedge clk_sys);
        idle_level <= inv;
        wr(8'h00, 32'hD);
        wr(8'h04, {26'h0, 1'b1, inv, 1'b0, act});
        burst(8'h06, 8'h28, 4'h2, 1'b1);
        rc(o_per, 32'h2D);
        rc(o_wid, 32'h05);
        rc(8'h10, 32'h30);
        burst(8'h06, 8'h28, 4'h1, 1'b0);
        rc(8'h10, 32'h32);
        rc(o_per, 32'h2D);
        $display("t_capture act %0d inv %0d done", act, inv);
    end
    endtask
    task t_width;
    begin
        rst;
        wr(8'h00, 32'hD);
        wr(8'h04, 32'h27);
        burst(8'h06, 8'h04, 4'h1, 1'b0);
        rc(8'h14, 32'h0);
        rc(8'h14, 32'h0);
        rc(8'h10, 32'h10);
        wr(8'h10, 32'h33);
        burst(8'h09, 8'h04, 4'h1, 1'b0);
        rd(8'h18);
        rv = (rv >= 32'h7 && rv <= 32'h9) ? 32'h1 : 32'h0;
        chk(32'h1);
        $display("t_width done");
    end
    endtask
    task t_gate;
    begin
        rst;
        wr(8'h18, 32'h1234);
        wr(8'h1C, 32'h4321);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h25);
        burst(8'h06, 8'h04, 4'h1, 1'b0);
        rc(8'h18, 32'h1234);
        rc(8'h10, 32'h0);
        wr(8'h14, 32'h1230);
        repeat (8) @(posedge clk_sys);
        rc(8'h10, 32'h10);
        wr(8'h10, 32'h33);
        wr(8'h00, 32'hD);
        wr(8'h04, 32'h05);
        burst(8'h06, 8'h04, 4'h1, 1'b0);
        rc(8'h10, 32'h0);
        rc(8'h1C, 32'h4321);
        $display("t_gate done");
    end
    endtask
    task t_actions;
    begin
        rst;
        wr(8'h04, 32'h20);
        burst(8'h02, 8'h02, 4'h3, 1'b0);
        rc(8'h14, 32'h0);
        wr(8'h04, 32'h22);
        wr(8'h00, 32'h1);
        burst(8'h02, 8'h02, 4'h3, 1'b0);
        rc(8'h14, 32'h3);
        rst;
        wr(8'h04, 32'h23);
        wr(8'h00, 32'h1);
        rc(8'h14, 32'h0);
        burst(8'h02, 8'h02, 4'h1, 1'b0);
        rd(8'h14);
        rv = (rv > 32'h0) ? 32'h1 : 32'h0;
        chk(32'h1);
        wr(8'h04, 32'h24);
        wr(8'h00, 32'h5);
        wr(8'h10, 32'h33);
        burst(8'h02, 8'h02, 4'h1, 1'b0);
        rc(8'h10, 32'h10);
        wr(8'h04, 32'h21);
        burst(8'h02, 8'h02, 4'h1, 1'b0);
        rd(8'h14);
        rv = (rv < 32'h20) ? 32'h1 : 32'h0;
        chk(32'h1);
        $display("t_actions done");
    end
    endtask
    task t_ovf;
    begin
        rst;
        wr(8'h04, 32'h100);
        wr(8'h14, 32'hFFF0);
        wr(8'h00, 32'h1);
        watch;
        chk(32'h1);
        wr(8'h04, 32'h0);
        wr(8'h14, 32'hFFF0);
        watch;
        chk(32'h0);
        wr(8'h04, 32'h100);
        wr(8'h00, 32'h3);
        wr(8'h14, 32'h000A);
        watch;
        chk(32'h1);
        $display("t_ovf done");
    end
    endtask
    task end_of_test;
    begin
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    initial
    begin
        t_regs;
        t_capture(3'h5, 1'b0, 8'h18, 8'h1C);
        t_capture(3'h6, 1'b0, 8'h1C, 8'h18);
        t_capture(3'h5, 1'b1, 8'h18, 8'h1C);
        t_width;
        t_gate;
        t_actions;
        t_ovf;
        end_of_test;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        miscompares = miscompares + 1;
        end_of_test;
    end
endmodule
bind timer_event_capture timer_event_capture_monitor mon (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .event_in(event_in),
    .overflow_event_out(overflow_event_out));
